// [verilog/otct_top.sv]
// How it works
// - ch5 captures subclock period count minus one into 16-bit register
// - ch1 captures timer input low width count minus one into 16-bit register
// - writing one to ch5 start bit sets ch5 enable and starts counting
// - writing one to ch1 start bit sets ch1 enable and starts counting
// - writing one to ch5 stop bit halts ch5 counting
// - writing one to ch1 stop bit halts ch1 counting
// - trim register is 8 bits, field 5..0, bits 7..6 read zero
// - trim zero is slowest oscillator, all ones fastest, monotonic
//
// Purpose: two capture channels and oscillator trim behind AXI4-Lite
// Assumes: subclock and timer input are asynchronous pins
// Notes: unmapped addresses answer SLVERR and read zero
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module otct_top
  import otct_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // reference pins
  input wire logic subclock_in,
  input wire logic channel1_timer_input_pin,
  // oscillator trim and channel enable status
  output logic [5:0] oscillator_trim_code,
  output logic [1:0] ch_enable_status,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ************************
  // pin synchronisers
  // ************************
  // both pins come from outside this clock's domain
  logic sub_rise;
  logic ti_rise;
  logic ti_fall;
  otct_pin_sync #(
    .IDLE(1'b0)
  ) otct_pin_sync_sub_i (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin(subclock_in),
    .rise(sub_rise),
    .fall()
  );
  // the timer input idles high
  otct_pin_sync #(
    .IDLE(1'b1)
  ) otct_pin_sync_ti_i (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .pin(channel1_timer_input_pin),
    .rise(ti_rise),
    .fall(ti_fall)
  );

  // ************************
  // bus write path
  // ************************
  logic aw_held;
  logic w_held;
  logic b_pend;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  // readies and valids drop while frozen, so no beat is taken or lost then
  assign s_axi_awready = clk_en && !aw_held && !b_pend;
  assign s_axi_wready = clk_en && !w_held && !b_pend;
  assign s_axi_bvalid = clk_en && b_pend;
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire have_aw = aw_held || aw_fire;
  wire have_w = w_held || w_fire;
  wire [7:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_go = have_aw && have_w && !b_pend;
  wire wr_map = (wr_addr == OTCT_ADDR_START) || (wr_addr == OTCT_ADDR_STOP)
    || (wr_addr == OTCT_ADDR_TRIM);
  // triggers are write-one pulses, zero bits do nothing; only low byte carries them
  wire start_wr = wr_go && (wr_addr == OTCT_ADDR_START) && wr_strb[0];
  wire stop_wr = wr_go && (wr_addr == OTCT_ADDR_STOP) && wr_strb[0];
  wire start5 = start_wr && wr_data[OTCT_BIT_CH5];
  wire start1 = start_wr && wr_data[OTCT_BIT_CH1];
  wire stop5 = stop_wr && wr_data[OTCT_BIT_CH5];
  wire stop1 = stop_wr && wr_data[OTCT_BIT_CH1];
  wire trim_wr = wr_go && (wr_addr == OTCT_ADDR_TRIM) && wr_strb[0];

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      b_pend <= 1'b0;
      s_axi_bresp <= OTCT_RESP_OKAY;
    end else if (clk_en) begin
      if (aw_fire && !wr_go) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire && !wr_go) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        b_pend <= 1'b1;
        s_axi_bresp <= wr_map ? OTCT_RESP_OKAY : OTCT_RESP_SLVERR;
      end else if (s_axi_bready) begin
        b_pend <= 1'b0;
      end
    end
  end

  // ************************
  // trim register
  // ************************
  // code drives the oscillator: zero slowest, all ones fastest
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      oscillator_trim_code <= OTCT_TRIM_RESET;
    end else if (clk_en && trim_wr) begin
      oscillator_trim_code <= wr_data[OTCT_TRIM_W-1:0];
    end
  end

  // ************************
  // channel 5: subclock interval
  // ************************
  logic en5;
  logic armed5;
  logic [15:0] cnt5;
  logic [15:0] subclock_interval_capture;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en5 <= 1'b0;
      armed5 <= 1'b0;
      cnt5 <= OTCT_CNT_ZERO;
      subclock_interval_capture <= OTCT_CNT_ZERO;
    end else if (clk_en) begin
      if (start5) begin
        en5 <= 1'b1;
        armed5 <= 1'b0;
        cnt5 <= OTCT_CNT_ZERO;
      end else if (stop5) begin
        en5 <= 1'b0;
      end else if (en5) begin
        if (sub_rise) begin
          // first edge only arms; later edges capture count minus one
          if (armed5) begin
            subclock_interval_capture <= cnt5 - OTCT_CNT_ONE;
          end
          armed5 <= 1'b1;
          cnt5 <= OTCT_CNT_ONE;
        end else if (cnt5 != OTCT_CNT_MAX) begin
          cnt5 <= cnt5 + OTCT_CNT_ONE;
        end
      end
    end
  end

  // ************************
  // channel 1: input low width
  // ************************
  logic en1;
  logic low1;
  logic [15:0] cnt1;
  logic [15:0] input_low_width_capture;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      en1 <= 1'b0;
      low1 <= 1'b0;
      cnt1 <= OTCT_CNT_ZERO;
      input_low_width_capture <= OTCT_CNT_ZERO;
    end else if (clk_en) begin
      if (start1) begin
        en1 <= 1'b1;
        low1 <= 1'b0;
        cnt1 <= OTCT_CNT_ZERO;
      end else if (stop1) begin
        en1 <= 1'b0;
        low1 <= 1'b0;
      end else if (en1) begin
        if (ti_fall) begin
          low1 <= 1'b1;
          cnt1 <= OTCT_CNT_ONE;
        end else if (ti_rise && low1) begin
          // saturating counter: an over-long pulse reads as FFFE, one below full scale
          input_low_width_capture <= cnt1 - OTCT_CNT_ONE;
          low1 <= 1'b0;
        end else if (low1 && cnt1 != OTCT_CNT_MAX) begin
          cnt1 <= cnt1 + OTCT_CNT_ONE;
        end
      end
    end
  end
  assign ch_enable_status = {en5, en1};

  // ************************
  // bus read path
  // ************************
  wire rd_cap5 = (s_axi_araddr == OTCT_ADDR_CAP5);
  wire rd_cap1 = (s_axi_araddr == OTCT_ADDR_CAP1);
  wire rd_trim = (s_axi_araddr == OTCT_ADDR_TRIM);
  wire rd_stat = (s_axi_araddr == OTCT_ADDR_STATUS);
  // trigger registers are write-only and read as zero
  wire rd_wo = (s_axi_araddr == OTCT_ADDR_START) || (s_axi_araddr == OTCT_ADDR_STOP);
  wire rd_map = rd_cap5 || rd_cap1 || rd_trim || rd_stat || rd_wo;
  wire [31:0] stat_word = (32'(en5) << OTCT_BIT_CH5) | (32'(en1) << OTCT_BIT_CH1);
  wire [31:0] rd_mux = rd_cap5 ? {16'h0000, subclock_interval_capture}
    : rd_cap1 ? {16'h0000, input_low_width_capture}
    : rd_trim ? {26'h0, oscillator_trim_code}
    : rd_stat ? stat_word
    : 32'h0000_0000;
  logic r_pend;
  assign s_axi_arready = clk_en && !r_pend;
  assign s_axi_rvalid = clk_en && r_pend;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_pend <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= OTCT_RESP_OKAY;
    end else if (clk_en) begin
      if (ar_fire) begin
        r_pend <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_map ? OTCT_RESP_OKAY : OTCT_RESP_SLVERR;
      end else if (s_axi_rready) begin
        r_pend <= 1'b0;
      end
    end
  end
endmodule // otct_top

// ************************
// pin synchroniser
// ************************
// three stages; a change counts once stages two and three agree
module otct_pin_sync
  import otct_pkg::*;
#(
  // level the pin rests at
  parameter logic IDLE = 1'b0
) (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // raw pin
  input wire logic pin,
  // one-cycle edge strobes
  output logic rise,
  output logic fall
);
  logic [2:0] stage;
  logic level;
  // only stage two reads stage one, which may still be settling
  wire agree = (stage[1] == stage[2]);
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stage <= {3{IDLE}};
      level <= IDLE;
    end else if (clk_en) begin
      stage <= {stage[1:0], pin};
      if (agree) begin
        level <= stage[2];
      end
    end
  end
  // level starts at the idle value, so leaving reset gives no false edge
  assign rise = agree && stage[2] && !level;
  assign fall = agree && !stage[2] && level;
endmodule // otct_pin_sync

// [verilog/otct_pkg.sv]
// Purpose: constants for the oscillator trim capture timer
// Assumes: AXI4-Lite register access, 32-bit data
// Notes: offsets are byte addresses
package otct_pkg;
  // ************************
  // register map
  // ************************
  localparam logic [7:0] OTCT_ADDR_CAP5 = 8'h00;
  localparam logic [7:0] OTCT_ADDR_CAP1 = 8'h04;
  localparam logic [7:0] OTCT_ADDR_START = 8'h08;
  localparam logic [7:0] OTCT_ADDR_STOP = 8'h0C;
  localparam logic [7:0] OTCT_ADDR_TRIM = 8'h10;
  localparam logic [7:0] OTCT_ADDR_STATUS = 8'h14;
  // ************************
  // fields
  // ************************
  localparam int OTCT_BIT_CH5 = 5;
  localparam int OTCT_BIT_CH1 = 1;
  localparam int OTCT_TRIM_W = 6;
  localparam logic [5:0] OTCT_TRIM_RESET = 6'h20;
  localparam logic [5:0] OTCT_TRIM_MIN = 6'h00;
  localparam logic [5:0] OTCT_TRIM_MAX = 6'h3F;
  localparam logic [1:0] OTCT_RESP_OKAY = 2'h0;
  localparam logic [1:0] OTCT_RESP_SLVERR = 2'h2;
  localparam logic [15:0] OTCT_CNT_ONE = 16'h0001;
  localparam logic [15:0] OTCT_CNT_ZERO = 16'h0000;
  localparam logic [15:0] OTCT_CNT_MAX = 16'hFFFF;
endpackage

// [verification/otct_monitor.sv]
// Purpose: assertion checker for the trim capture timer
// Assumes: address and data of a write offered in one cycle
// Notes: bound to otct_top at the foot of this file
`timescale 1ns/1ps
module otct_monitor
  import otct_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  // bus handshakes
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // block outputs
  input wire logic [5:0] oscillator_trim_code,
  input wire logic [1:0] ch_enable_status
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // only lane 0 carries trigger and trim bits
  wire wr = s_axi_awvalid && s_axi_awready && clk_en
    && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire st = wr && s_axi_awaddr == OTCT_ADDR_START;
  wire sp = wr && s_axi_awaddr == OTCT_ADDR_STOP;
  wire tr = wr && s_axi_awaddr == OTCT_ADDR_TRIM;
  wire st5 = st && s_axi_wdata[5];
  wire [5:0] wtrim = s_axi_wdata[5:0];
  // ************************
  // properties
  // ************************
  // ************************
  sequence s_trig(hit, b);
    hit && s_axi_wdata[b];
  endsequence
  a_start_ch5: assert property (s_trig(st, 5) |=> ch_enable_status[1])
    else $error("ch5 start did not enable");
  a_start_ch1: assert property (s_trig(st, 1) |=> ch_enable_status[0])
    else $error("ch1 start did not enable");
  a_stop_ch5: assert property (s_trig(sp, 5) |=> !ch_enable_status[1])
    else $error("ch5 stop did not halt");
  a_stop_ch1: assert property (s_trig(sp, 1) |=> !ch_enable_status[0])
    else $error("ch1 stop did not halt");
  a_en5_cause: assert property ($rose(ch_enable_status[1]) |-> $past(st5))
    else $error("ch5 enabled without a start");
  a_trim_write: assert property (tr |=> oscillator_trim_code == $past(wtrim))
    else $error("trim code not taken from write");
  a_trim_hold: assert property (!tr |=> $stable(oscillator_trim_code))
    else $error("trim code moved without a write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late or address not held off");
endmodule // otct_monitor

bind otct_top otct_monitor otct_monitor_i (.clk_sys, .resetn, .clk_en, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .oscillator_trim_code, .ch_enable_status);

// [verification/otct_ref_pins.sv]
// Purpose: reference subclock and external low pulse source
// Assumes: pins change just after a clock edge
// Notes: period and low width in clocks, set by the bench
`timescale 1ns/1ps
module otct_ref_pins (
  // clock, reset
  input wire logic clk_sys,
  input wire logic resetn,
  // pulse shape
  input wire logic [15:0] per,
  input wire logic [15:0] low,
  // reference pins
  output logic subclock_in,
  output logic channel1_timer_input_pin
);
  logic [15:0] cnt;
  // free running, as a crystal reference would be
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt <= 16'h0;
      subclock_in <= 1'h0;
      channel1_timer_input_pin <= 1'h1;
    end else begin
      cnt <= (cnt >= per - 16'h1) ? 16'h0 : cnt + 16'h1;
      subclock_in <= cnt < (per >> 1);
      channel1_timer_input_pin <= cnt >= low;
    end
  end
endmodule // otct_ref_pins

// [verification/oscillator_trim_capture_timer_tb.sv]
// Purpose: self-checking bench for otct_top
// Assumes: one bus access at a time, clock enable high except in the frozen read test
// Notes: expected answers queued by the driver, checked on response
`timescale 1ns/1ps
module oscillator_trim_capture_timer_tb
  import otct_pkg::*;
;
  logic clk_sys = 1'h0, resetn = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0;
  logic rry = 1'h0, ce = 1'h1;
  logic [3:0] ws = 4'hF;
  logic [5:0] c;
  logic [7:0] awa = 8'h0, ara = 8'h0;
  logic [31:0] wd = 32'h0;
  logic [15:0] per = 16'h28, low = 16'h8, p, l;
  logic [7:0] tv[3] = '{8'h3F, 8'h00, 8'hC1};
  logic [33:0] q[$];
  wire awr, wrd, bv, arr, rv, sub, pin;
  wire [1:0] br, rr, en;
  wire [5:0] trim;
  wire [31:0] rd;
  int bad_count = 0, tests_run = 0;
  always #20 clk_sys = ~clk_sys;
  otct_top otct_top_i (.clk_sys, .resetn, .clk_en(ce), .subclock_in(sub),
    .channel1_timer_input_pin(pin), .oscillator_trim_code(trim), .ch_enable_status(en),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rry));
  otct_ref_pins otct_ref_pins_i (.clk_sys, .resetn, .per, .low, .subclock_in(sub),
    .channel1_timer_input_pin(pin));
  // ************************
  // bus tasks and checking
  // ************************
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t saw %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, 32'h0});
    @(posedge clk_sys);
    awa <= a;
    wd <= d;
    {awv, wv, bry} <= 3'h7;
    do begin
      @(posedge clk_sys);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
    end while (bv !== 1'h1);
    bry <= 1'h0;
  endtask
  task automatic rdx(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    q.push_back({r, d});
    @(posedge clk_sys);
    ara <= a;
    {arv, rry} <= 2'h3;
    do begin
      @(posedge clk_sys);
      if (arr) arv <= 1'h0;
    end while (rv !== 1'h1);
    rry <= 1'h0;
  endtask
  // answers are compared in the order they were requested
  always @(posedge clk_sys) begin
    if (bv && bry) chk({br, 32'h0}, q.pop_front());
    if (rv && rry) chk({rr, rd}, q.pop_front());
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(66507));
    repeat (10) @(posedge clk_sys);
    resetn <= 1'h1;
    rdx(OTCT_ADDR_TRIM, 32'h20, 2'h0);
    wr(OTCT_ADDR_START, 32'h0, 2'h0);
    rdx(OTCT_ADDR_STATUS, 32'h0, 2'h0);
    for (int k = 0; k < 2; k++) begin
      p = 16'($urandom_range(60, 20));
      l = 16'($urandom_range(9, 3));
      per <= p;
      low <= l;
      wr(OTCT_ADDR_START, 32'h22, 2'h0);
      repeat (5 * p) @(posedge clk_sys);
      rdx(OTCT_ADDR_STATUS, 32'h22, 2'h0);
      rdx(OTCT_ADDR_CAP5, 32'(p - 16'h1), 2'h0);
      rdx(OTCT_ADDR_CAP1, 32'(l - 16'h1), 2'h0);
      wr(OTCT_ADDR_STOP, 32'h0, 2'h0);
    end
    wr(OTCT_ADDR_STOP, 32'h22, 2'h0);
    rdx(OTCT_ADDR_STATUS, 32'h0, 2'h0);
    per <= p + 16'h7;
    low <= l + 16'h2;
    repeat (5 * p + 50) @(posedge clk_sys);
    rdx(OTCT_ADDR_CAP5, 32'(p - 16'h1), 2'h0);
    rdx(OTCT_ADDR_CAP1, 32'(l - 16'h1), 2'h0);
    foreach (tv[i]) begin
      wr(OTCT_ADDR_TRIM, {24'h0, tv[i]}, 2'h0);
      rdx(OTCT_ADDR_TRIM, {26'h0, tv[i][5:0]}, 2'h0);
    end
    // count above target means a fast oscillator: step down, never past the ends
    c = 6'($urandom_range(2, 1));
    for (int k = 0; k < 4; k++) begin
      wr(OTCT_ADDR_TRIM, {26'h0, c}, 2'h0);
      rdx(OTCT_ADDR_TRIM, {26'h0, c}, 2'h0);
      if (p > 16'h10) c = (c == OTCT_TRIM_MIN) ? c : c - 6'h1;
      else c = (c == OTCT_TRIM_MAX) ? c : c + 6'h1;
    end
    // lane 0 off: the write is answered but moves nothing
    ws <= 4'hE;
    wr(OTCT_ADDR_TRIM, 32'h15, 2'h0);
    ws <= 4'hF;
    // frozen: the read waits until the enable returns
    ce <= 1'h0;
    fork
      rdx(OTCT_ADDR_TRIM, {26'h0, c}, 2'h0);
      begin
        repeat (6) begin
          @(posedge clk_sys);
          chk(34'(rv), 34'h0);
        end
        ce <= 1'h1;
      end
    join
    rdx(OTCT_ADDR_START, 32'h0, 2'h0);
    wr(OTCT_ADDR_CAP5, 32'h1, OTCT_RESP_SLVERR);
    finish_test();
  end
  // whole run is about a thousand clocks at most
  initial begin
    #(40 * 20000);
    bad_count++;
    finish_test();
  end
endmodule // oscillator_trim_capture_timer_tb
